// ---- rtl/olbt_pkg.sv ----
// Shared constants, types and decode functions for the octal latched bus transceiver
package olbt_pkg;

  // ----------------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------------
  localparam int          BUS_W      = 8;
  localparam int          CTRL_W     = 6;
  localparam logic [7:0]  LATCH_RST  = 8'h00;
  localparam logic [7:0]  OBS_RST    = 8'h00;
  localparam logic [5:0]  CTRL_RST   = 6'h3f;

  // ----------------------------------------------------------------------
  // Control snapshot field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_AB_LE = 0;
  localparam int CTRL_AB_CE = 1;
  localparam int CTRL_AB_OE = 2;
  localparam int CTRL_BA_LE = 3;
  localparam int CTRL_BA_CE = 4;
  localparam int CTRL_BA_OE = 5;

  // ----------------------------------------------------------------------
  // Boundary ownership, Gray coded
  // ----------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    MODE_NORMAL = 2'b00,
    MODE_TEST   = 2'b01
  } olbt_mode_t;

  // ----------------------------------------------------------------------
  // Decode shared by both directions
  // ----------------------------------------------------------------------
  function automatic logic olbtFollows(input logic latchEnN, input logic chipEnN);
    olbtFollows = ~latchEnN & ~chipEnN;
  endfunction : olbtFollows

  function automatic logic olbtDrives(input logic outEnN, input logic chipEnN);
    olbtDrives = ~outEnN & ~chipEnN;
  endfunction : olbtDrives

endpackage : olbt_pkg

// ---- rtl/olbt_dir_latch.sv ----
// One direction of the transceiver: an eight-bit data latch and its drive decode
`timescale 1ns/10ps
module olbt_dir_latch
(
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          reset_n,
  input  wire logic                          clkEn,
  // Normal-mode controls, active low
  input  wire logic                          latchEnN,
  input  wire logic                          chipEnN,
  input  wire logic                          outEnN,
  // Freezes the latch while test logic owns the boundary
  input  wire logic                          inhibit,
  // Data
  input  wire logic [olbt_pkg::BUS_W-1:0]    dataIn,
  output logic      [olbt_pkg::BUS_W-1:0]    dataOut,
  output logic                               drive
);

  // ----------------------------------------------------------------------
  // Latch
  // ----------------------------------------------------------------------
  logic [olbt_pkg::BUS_W-1:0] latch_r;
  logic [olbt_pkg::BUS_W-1:0] latch_nxt;

  always_comb
  begin
    latch_nxt = latch_r;
    if (!inhibit && olbt_pkg::olbtFollows(latchEnN, chipEnN))
    begin
      latch_nxt = dataIn;
    end
    // Otherwise the captured value stays, so the output keeps its level
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      latch_r <= olbt_pkg::LATCH_RST;
    end
    else if (clkEn)
    begin
      latch_r <= latch_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign dataOut = latch_r;
  // High impedance regardless of latch state when either enable is high
  assign drive   = olbt_pkg::olbtDrives(outEnN, chipEnN);

endmodule : olbt_dir_latch

// ---- rtl/olbt_transceiver.sv ----
// Top level of the octal latched bus transceiver datapath with test-mode boundary handover
//
// Behaviour
// - A to B transparent when latch, chip low
// - Latch or chip high holds captured A
// - Drive B only when output, chip low
// - Otherwise B is high impedance
// - B to A mirrors it, own controls
// - Held latch keeps previous output level
// - Test mode hands boundary to test logic
// - Test activity sequenced by test port; reset_n also ends it
// - Test port reset keeps normal behaviour
`timescale 1ns/10ps
module olbt_transceiver
(
  // Clock, reset and clock enable
  input  wire logic                          core_clk,
  input  wire logic                          reset_n,
  input  wire logic                          clkEn,

  // A-to-B controls, active low
  input  wire logic                          a_to_b_latch_enable_n,
  input  wire logic                          a_to_b_chip_enable_n,
  input  wire logic                          a_to_b_output_enable_n,

  // B-to-A controls, active low
  input  wire logic                          b_to_a_latch_enable_n,
  input  wire logic                          b_to_a_chip_enable_n,
  input  wire logic                          b_to_a_output_enable_n,

  // A bus pins
  input  wire logic [olbt_pkg::BUS_W-1:0]    aIn,
  output logic      [olbt_pkg::BUS_W-1:0]    aOut,
  output logic      [olbt_pkg::BUS_W-1:0]    aOe,

  // B bus pins
  input  wire logic [olbt_pkg::BUS_W-1:0]    bIn,
  output logic      [olbt_pkg::BUS_W-1:0]    bOut,
  output logic      [olbt_pkg::BUS_W-1:0]    bOe,

  // Status from the test access port controller
  input  wire logic                          testModeReq,
  input  wire logic                          tapInReset,

  // Boundary control from the test logic
  input  wire logic [olbt_pkg::BUS_W-1:0]    testAData,
  input  wire logic [olbt_pkg::BUS_W-1:0]    testAOe,
  input  wire logic [olbt_pkg::BUS_W-1:0]    testBData,
  input  wire logic [olbt_pkg::BUS_W-1:0]    testBOe,

  // Boundary observation for the test logic
  output logic      [olbt_pkg::BUS_W-1:0]    obsA,
  output logic      [olbt_pkg::BUS_W-1:0]    obsB,
  output logic      [olbt_pkg::CTRL_W-1:0]   obsCtrl,
  output logic                               testActive
);

  // ----------------------------------------------------------------------
  // Boundary ownership
  // ----------------------------------------------------------------------
  // Two states only; the port controller itself lives outside this block
  olbt_pkg::olbt_mode_t mode_r;
  olbt_pkg::olbt_mode_t mode_nxt;

  always_comb
  begin
    mode_nxt = mode_r;
    case (mode_r)
      olbt_pkg::MODE_NORMAL:
      begin
        if (testModeReq && !tapInReset)
        begin
          mode_nxt = olbt_pkg::MODE_TEST;
        end
      end
      olbt_pkg::MODE_TEST:
      begin
        // Reset state of the port always wins over a stale test request
        if (tapInReset || !testModeReq)
        begin
          mode_nxt = olbt_pkg::MODE_NORMAL;
        end
      end
      default:
      begin
        mode_nxt = olbt_pkg::MODE_NORMAL;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_r <= olbt_pkg::MODE_NORMAL;
    end
    else if (clkEn)
    begin
      mode_r <= mode_nxt;
    end
  end

  // Gates the pin mux and freezes both latches while test logic owns the pins
  logic inTest;

  // Combinational on the port reset so normal function returns at once
  assign inTest     = (mode_r == olbt_pkg::MODE_TEST) && !tapInReset;
  assign testActive = inTest;

  // ----------------------------------------------------------------------
  // Directional latches
  // ----------------------------------------------------------------------
  logic [olbt_pkg::BUS_W-1:0] abData;
  logic [olbt_pkg::BUS_W-1:0] baData;
  logic                       abDrive;
  logic                       baDrive;

  // Clocked latches: transparency costs one cycle of latency, traded for
  // a single clock domain with no level-sensitive storage
  // Separate instances so one direction never disturbs the other
  olbt_dir_latch uAtoB
  (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .clkEn    (clkEn),
    .latchEnN (a_to_b_latch_enable_n),
    .chipEnN  (a_to_b_chip_enable_n),
    .outEnN   (a_to_b_output_enable_n),
    .inhibit  (inTest),
    .dataIn   (aIn),
    .dataOut  (abData),
    .drive    (abDrive)
  );

  olbt_dir_latch uBtoA
  (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .clkEn    (clkEn),
    .latchEnN (b_to_a_latch_enable_n),
    .chipEnN  (b_to_a_chip_enable_n),
    .outEnN   (b_to_a_output_enable_n),
    .inhibit  (inTest),
    .dataIn   (bIn),
    .dataOut  (baData),
    .drive    (baDrive)
  );

  // ----------------------------------------------------------------------
  // Pin multiplexing
  // ----------------------------------------------------------------------
  // Enables stay combinational so a bus is let go in the very cycle the
  // controls ask for it; in normal mode the drive values come from registers
  always_comb
  begin
    if (inTest)
    begin
      // Normal controls are ignored; only the test logic steers the pins
      bOut = testBData;
      bOe  = testBOe;
      aOut = testAData;
      aOe  = testAOe;
    end
    else
    begin
      bOut = abData;
      bOe  = {olbt_pkg::BUS_W{abDrive}};
      aOut = baData;
      aOe  = {olbt_pkg::BUS_W{baDrive}};
    end
  end

  // ----------------------------------------------------------------------
  // Boundary observation
  // ----------------------------------------------------------------------
  // Sampled in both modes so a snapshot of normal traffic is always ready
  // Frozen with the rest of the state while the clock enable is low
  logic [olbt_pkg::BUS_W-1:0]  obsA_r;
  logic [olbt_pkg::BUS_W-1:0]  obsA_nxt;
  logic [olbt_pkg::BUS_W-1:0]  obsB_r;
  logic [olbt_pkg::BUS_W-1:0]  obsB_nxt;
  logic [olbt_pkg::CTRL_W-1:0] obsCtrl_r;
  logic [olbt_pkg::CTRL_W-1:0] obsCtrl_nxt;

  always_comb
  begin
    obsA_nxt                          = aIn;
    obsB_nxt                          = bIn;
    obsCtrl_nxt                       = obsCtrl_r;
    obsCtrl_nxt[olbt_pkg::CTRL_AB_LE] = a_to_b_latch_enable_n;
    obsCtrl_nxt[olbt_pkg::CTRL_AB_CE] = a_to_b_chip_enable_n;
    obsCtrl_nxt[olbt_pkg::CTRL_AB_OE] = a_to_b_output_enable_n;
    obsCtrl_nxt[olbt_pkg::CTRL_BA_LE] = b_to_a_latch_enable_n;
    obsCtrl_nxt[olbt_pkg::CTRL_BA_CE] = b_to_a_chip_enable_n;
    obsCtrl_nxt[olbt_pkg::CTRL_BA_OE] = b_to_a_output_enable_n;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      obsA_r    <= olbt_pkg::OBS_RST;
      obsB_r    <= olbt_pkg::OBS_RST;
      obsCtrl_r <= olbt_pkg::CTRL_RST;
    end
    else if (clkEn)
    begin
      obsA_r    <= obsA_nxt;
      obsB_r    <= obsB_nxt;
      obsCtrl_r <= obsCtrl_nxt;
    end
  end

  assign obsA    = obsA_r;
  assign obsB    = obsB_r;
  assign obsCtrl = obsCtrl_r;

endmodule : olbt_transceiver

// ---- tb/olbt_bus_model.sv ----
// Board-side drivers sharing the A and B buses with the transceiver
`timescale 1ns/10ps
module olbt_bus_model
(
  // Transceiver pin drive
  input  wire logic [7:0] aOut,
  input  wire logic [7:0] aOe,
  input  wire logic [7:0] bOut,
  input  wire logic [7:0] bOe,
  // Board data offered while the transceiver lets go
  input  wire logic [7:0] aDrv,
  input  wire logic [7:0] bDrv,
  // Resolved wire levels
  output logic      [7:0] aIn,
  output logic      [7:0] bIn
);
  // Board yields bit by bit so a driven pin never fights the device
  assign aIn = (aOe & aOut) | (~aOe & aDrv);
  assign bIn = (bOe & bOut) | (~bOe & bDrv);
endmodule : olbt_bus_model

// ---- tb/olbt_transceiver_asserts.sv ----
// Port-level checks for the transceiver datapath
`timescale 1ns/10ps
module olbt_transceiver_asserts
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       reset_n,
  input wire logic       clkEn,
  // Controls, active low
  input wire logic       a_to_b_latch_enable_n,
  input wire logic       a_to_b_chip_enable_n,
  input wire logic       a_to_b_output_enable_n,
  input wire logic       b_to_a_latch_enable_n,
  input wire logic       b_to_a_chip_enable_n,
  input wire logic       b_to_a_output_enable_n,
  // Pins and test boundary
  input wire logic [7:0] aIn,
  input wire logic [7:0] bIn,
  input wire logic [7:0] aOut,
  input wire logic [7:0] bOut,
  input wire logic [7:0] aOe,
  input wire logic [7:0] bOe,
  input wire logic [7:0] testAData,
  input wire logic [7:0] testAOe,
  input wire logic [7:0] testBData,
  input wire logic [7:0] testBOe,
  input wire logic       testModeReq,
  input wire logic       tapInReset,
  input wire logic       testActive
);
  // ------
  // Checks
  // ------
  // Test port reset is left out of loads since its latch behaviour there is open
  wire abGo = !a_to_b_latch_enable_n && !a_to_b_chip_enable_n && clkEn && !tapInReset;
  wire baGo = !b_to_a_latch_enable_n && !b_to_a_chip_enable_n && clkEn && !tapInReset;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_abLoad; abGo && !testActive |=> testActive || bOut == $past(aIn); endproperty
  a_abLoad: assert property (p_abLoad) else $error("B missed A load");
  property p_abHold;
    !testActive && (a_to_b_latch_enable_n || a_to_b_chip_enable_n) |=> testActive || $stable(bOut);
  endproperty
  a_abHold: assert property (p_abHold) else $error("B latch moved");
  property p_bOe;
    !testActive |-> bOe == {8{!a_to_b_output_enable_n && !a_to_b_chip_enable_n}};
  endproperty
  a_bOe: assert property (p_bOe) else $error("B enable wrong");
  property p_aOe;
    !testActive |-> aOe == {8{!b_to_a_output_enable_n && !b_to_a_chip_enable_n}};
  endproperty
  a_aOe: assert property (p_aOe) else $error("A enable wrong");
  property p_baLoad; baGo && !testActive |=> testActive || aOut == $past(bIn); endproperty
  a_baLoad: assert property (p_baLoad) else $error("A missed B load");
  property p_baHold;
    !testActive && (b_to_a_latch_enable_n || b_to_a_chip_enable_n) |=> testActive || $stable(aOut);
  endproperty
  a_baHold: assert property (p_baHold) else $error("A latch moved");
  property p_test;
    testActive |-> bOut == testBData && bOe == testBOe && aOut == testAData && aOe == testAOe;
  endproperty
  a_test: assert property (p_test) else $error("Boundary not handed over");
  property p_enter; $rose(testActive) |-> $past(testModeReq) && !tapInReset; endproperty
  a_enter: assert property (p_enter) else $error("Test entered unasked");
  property p_tapRst; tapInReset |-> !testActive; endproperty
  a_tapRst: assert property (p_tapRst) else $error("Test active in port reset");
  c_abLoad: cover property (abGo && !testActive);
  c_baLoad: cover property (baGo && !testActive);
  c_enter: cover property ($rose(testActive));
endmodule : olbt_transceiver_asserts
bind olbt_transceiver olbt_transceiver_asserts u_chk (.*);

// ---- tb/olbt_transceiver_bench.sv ----
// Self-checking bench for the transceiver datapath
`timescale 1ns/10ps
module olbt_transceiver_bench;
  // ------
  // Set-up
  // ------
  logic       core_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       clkEn = 1'b1;
  logic       testModeReq = 1'b0;
  logic       tapInReset = 1'b0;
  logic       testActive;
  logic [5:0] ctlN = 6'h3f;
  logic [7:0] aDrv = 8'h00, bDrv = 8'h00, aIn, bIn, aOut, bOut, aOe, bOe;
  logic [7:0] obsA, obsB;
  logic [5:0] obsCtrl;
  int         n_fail = 0;
  int         checked = 0;
  always #4 core_clk = ~core_clk;
  olbt_transceiver u_dut (.core_clk, .reset_n, .clkEn, .a_to_b_latch_enable_n(ctlN[0]),
    .a_to_b_chip_enable_n(ctlN[1]), .a_to_b_output_enable_n(ctlN[2]),
    .b_to_a_latch_enable_n(ctlN[3]), .b_to_a_chip_enable_n(ctlN[4]),
    .b_to_a_output_enable_n(ctlN[5]), .aIn, .aOut, .aOe, .bIn, .bOut, .bOe, .testModeReq,
    .tapInReset, .testAData(8'h77), .testAOe(8'hf0), .testBData(8'h3c), .testBOe(8'h0f),
    .obsA, .obsB, .obsCtrl, .testActive);
  olbt_bus_model u_bus (.aOut, .aOe, .bOut, .bOe, .aDrv, .bDrv, .aIn, .bIn);
  // ------
  // Tasks
  // ------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic drive(input logic e, input logic [5:0] c, input logic [7:0] a,
                       input logic [7:0] b);
    @(posedge core_clk);
    clkEn <= e;
    ctlN <= c;
    aDrv <= a;
    bDrv <= b;
    #1;
  endtask : drive
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask : tick
  task automatic t_pass;
    drive(1'b1, 6'h38, 8'h5a, 8'h00);
    chk("bOe", bOe, 8'hff);
    chk("aOe", aOe, 8'h00);
    tick;
    chk("bOut", bOut, 8'h5a);
    chk("obsA", obsA, 8'h5a);
    chk("obsCtrl", {2'b00, obsCtrl}, 8'h38);
  endtask : t_pass
  task automatic t_hold;
    drive(1'b1, 6'h39, 8'h00, 8'h00);
    tick;
    chk("bOut", bOut, 8'h5a);
    drive(1'b1, 6'h3a, 8'h81, 8'h00);
    chk("bOe", bOe, 8'h00);
    tick;
    chk("bOut", bOut, 8'h5a);
    drive(1'b1, 6'h3c, 8'hc3, 8'h00);
    chk("bOe", bOe, 8'h00);
    tick;
    chk("bOut", bOut, 8'hc3);
  endtask : t_hold
  task automatic t_ba;
    drive(1'b1, 6'h05, 8'h00, 8'h96);
    chk("aOe", aOe, 8'hff);
    tick;
    chk("aOut", aOut, 8'h96);
    chk("bOut", bOut, 8'hc3);
  endtask : t_ba
  task automatic t_freeze;
    drive(1'b0, 6'h38, 8'h11, 8'h00);
    tick;
    chk("bOut", bOut, 8'hc3);
    chk("obsCtrl", {2'b00, obsCtrl}, 8'h05);
  endtask : t_freeze
  task automatic t_test;
    @(posedge core_clk);
    clkEn <= 1'b1;
    ctlN <= 6'h38;
    aDrv <= 8'h11;
    bDrv <= 8'h00;
    testModeReq <= 1'b1;
    #1;
    tick;
    chk("testActive", {7'h00, testActive}, 8'h01);
    chk("bOut", bOut, 8'h3c);
    chk("aOe", aOe, 8'hf0);
    drive(1'b1, 6'h38, 8'h22, 8'h00);
    chk("obsA", obsA, 8'h71);
    chk("obsB", obsB, 8'h0c);
    tick;
    @(posedge core_clk);
    tapInReset <= 1'b1;
    testModeReq <= 1'b0;
    #1;
    chk("testActive", {7'h00, testActive}, 8'h00);
    chk("bOut", bOut, 8'h11);
    tick;
    @(posedge core_clk);
    tapInReset <= 1'b0;
    tick;
    chk("testActive", {7'h00, testActive}, 8'h00);
    chk("bOut", bOut, 8'h22);
  endtask : t_test
  task automatic finish_test;
    if (n_fail == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  // ------
  // Run
  // ------
  initial
  begin
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    #1;
    chk("bOut", bOut, olbt_pkg::LATCH_RST);
    chk("obsCtrl", {2'b00, obsCtrl}, {2'b00, olbt_pkg::CTRL_RST});
    t_pass;
    t_hold;
    t_ba;
    t_freeze;
    t_test;
    finish_test;
  end
  // About twenty-five cycles are needed; a hang is cut well after that
  initial
  begin
    #2000;
    n_fail++;
    finish_test;
  end
endmodule : olbt_transceiver_bench
